// >>> hw/cfs_supervisor.sv
`timescale 1ns/1ns
module cfs_supervisor
	import cfs_pkg::*;
#(
	parameter int UNIT_PER_DEG = 1,
	parameter int CUR_LIMIT = CUR_LIMIT_DA
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire cfs_bus_t bus,
	output logic [DW-1:0] rd_data,
	input wire logic signed [PV_W-1:0] process_value,
	input wire logic [CUR_W-1:0] heater_cur,
	input wire cfs_sel_t disp_sel,
	input wire logic ctrl_req_on,
	input wire logic [MV_W-1:0] ctrl_req_val,
	input wire logic [ALM_N-1:0] alarm_req,
	input wire logic [ALM_N-1:0] alarm_hi_resp,
	input wire logic manual_act,
	input wire logic reset_act,
	input wire logic [2:0] pin_rtd_open,
	input wire logic pin_adc_fault,
	input wire logic pin_mem_fault,
	output cfs_out_t out,
	output logic irq
);

	// =====================================================
	// state
	cfs_st_t st_reg;
	cfs_st_t st_next;

	logic signed [31:0] pv;
	logic signed [31:0] lo;
	logic signed [31:0] hi;
	logic signed [31:0] margin;
	logic signed [31:0] span;
	logic signed [31:0] dpv;
	cfs_kind_t kind;
	logic rtd_open;
	logic in_range;
	logic in_fault;
	logic ovr_lo;
	logic ovr_hi;
	logic adc_f;
	logic mem_f;
	logic cur_over;
	logic show_val;
	logic show_ovr;
	logic [EV_N-1:0] ev;
	logic rd_status;

	function automatic cfs_code_t pick_code(input logic mem, input logic adc,
		input logic inp, input logic olo, input logic ohi, input logic cur);
		if (mem)
			return CODE_MEM;
		else if (adc)
			return CODE_ADC;
		else if (inp)
			return CODE_INPUT;
		else if (olo)
			return CODE_OVR_LO;
		else if (ohi)
			return CODE_OVR_HI;
		else if (cur)
			return CODE_CUR;
		return CODE_NONE;
	endfunction

	// =====================================================
	// classification
	always_comb
	begin
		pv = 32'(process_value);
		lo = 32'(signed'(st_reg.lo));
		hi = 32'(signed'(st_reg.hi));
		kind = cfs_kind_t'(st_reg.cfg[CFG_KIND +: 2]);
		// fahrenheit degrees are finer, so the margin doubles
		margin = st_reg.cfg[CFG_FAHR] ? 32'(MARGIN_F * UNIT_PER_DEG) : 32'(MARGIN_C * UNIT_PER_DEG);
		span = hi - lo;
		dpv = pv - lo;
		if (kind == KIND_ANA)
			// scaled by 100 to avoid a divider
			in_range = (dpv * 100 >= span * ANA_LO_PCT) && (dpv * 100 <= span * ANA_HI_PCT);
		else
			in_range = (pv >= lo - margin) && (pv <= hi + margin);
		rtd_open = (kind == KIND_RTD) && (|st_reg.s2[2:0]);
		in_fault = !in_range || rtd_open;
		ovr_lo = !in_fault && (pv < DISP_MIN);
		ovr_hi = !in_fault && (pv > DISP_MAX);
		adc_f = st_reg.s2[3];
		mem_f = st_reg.s2[4];
		cur_over = 32'(heater_cur) > CUR_LIMIT;
		show_val = (disp_sel == SEL_PV) || (disp_sel == SEL_PV_SP) || (disp_sel == SEL_PV_MV);
		show_ovr = show_val || (disp_sel == SEL_RSP);
		ev = '0;
		ev[EV_INPUT] = in_fault;
		ev[EV_OVR] = ovr_lo || ovr_hi;
		ev[EV_ADC] = adc_f;
		ev[EV_MEM] = mem_f;
		ev[EV_CUR] = cur_over;
		rd_status = bus.rd && (bus.addr == ADDR_STATUS);
	end

	// =====================================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		// pin synchronisers
		st_next.s1 = {pin_mem_fault, pin_adc_fault, pin_rtd_open};
		st_next.s2 = st_reg.s1;
		if (bus.wr)
		begin
			unique case (bus.addr)
				ADDR_CFG: st_next.cfg = bus.wdata[7:0];
				ADDR_LO: st_next.lo = bus.wdata[PV_W-1:0];
				ADDR_HI: st_next.hi = bus.wdata[PV_W-1:0];
				ADDR_MV_ERR: st_next.mv_err = bus.wdata[MV_W-1:0];
				ADDR_MV_MAN: st_next.mv_man = bus.wdata[MV_W-1:0];
				ADDR_MV_RST: st_next.mv_rst = bus.wdata[MV_W-1:0];
				ADDR_MASK: st_next.mask = bus.wdata[EV_N-1:0];
				default: ;
			endcase
		end
		st_next.rdata = '0;
		if (bus.rd)
		begin
			unique case (bus.addr)
				ADDR_CFG: st_next.rdata = {24'h000000, st_reg.cfg};
				ADDR_LO: st_next.rdata = 32'(signed'(st_reg.lo));
				ADDR_HI: st_next.rdata = 32'(signed'(st_reg.hi));
				ADDR_MV_ERR: st_next.rdata = {16'h0000, st_reg.mv_err};
				ADDR_MV_MAN: st_next.rdata = {16'h0000, st_reg.mv_man};
				ADDR_MV_RST: st_next.rdata = {16'h0000, st_reg.mv_rst};
				ADDR_STATUS: st_next.rdata = {27'h0000000, st_reg.status};
				ADDR_MASK: st_next.rdata = {27'h0000000, st_reg.mask};
				ADDR_LIVE: st_next.rdata = {27'h0000000, ev};
				default: st_next.rdata = '0;
			endcase
		end
		// set beats the read-clear
		st_next.status = (rd_status ? '0 : st_reg.status) | ev;

		// control and alarm outputs
		st_next.out.cur_zero = 1'b0;
		if (adc_f || mem_f)
		begin
			// internal faults outrank every fallback value
			st_next.out.ctrl_on = 1'b0;
			st_next.out.ctrl_val = '0;
			st_next.out.alarm = '0;
			st_next.out.cur_zero = mem_f;
		end
		else if (in_fault)
		begin
			st_next.out.alarm = alarm_hi_resp;
			if (st_reg.cfg[CFG_FTA])
				st_next.out.alarm[0] = 1'b1;
			if (manual_act && st_reg.cfg[CFG_MANMV])
			begin
				st_next.out.ctrl_on = 1'b1;
				st_next.out.ctrl_val = st_reg.mv_man;
			end
			else if (reset_act && st_reg.cfg[CFG_RSTMV])
			begin
				st_next.out.ctrl_on = 1'b1;
				st_next.out.ctrl_val = st_reg.mv_rst;
			end
			else if (st_reg.cfg[CFG_ERRMV])
			begin
				st_next.out.ctrl_on = 1'b1;
				st_next.out.ctrl_val = st_reg.mv_err;
			end
			else
			begin
				st_next.out.ctrl_on = 1'b0;
				st_next.out.ctrl_val = '0;
			end
		end
		else
		begin
			// overrange does not disturb control
			st_next.out.ctrl_on = ctrl_req_on;
			st_next.out.ctrl_val = ctrl_req_val;
			st_next.out.alarm = alarm_req;
		end

		// display routing
		st_next.out.disp1 = pick_code(mem_f, adc_f, in_fault && show_val,
			ovr_lo && show_ovr, ovr_hi && show_ovr, cur_over && !st_reg.cfg[CFG_CUR2]);
		st_next.out.disp2 = (cur_over && st_reg.cfg[CFG_CUR2]) ? CODE_CUR : CODE_NONE;
		st_next.out.ovr_pv = (ovr_lo || ovr_hi) && show_val;
		st_next.out.ovr_rsp = (ovr_lo || ovr_hi) && (disp_sel == SEL_RSP);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.cfg <= CFG_RST;
			st_reg.lo <= LO_RST;
			st_reg.hi <= HI_RST;
			st_reg.mv_err <= MV_RST;
			st_reg.mv_man <= MV_RST;
			st_reg.mv_rst <= MV_RST;
			st_reg.mask <= MASK_RST;
		end
		else
			st_reg <= st_next;
	end

	assign out = st_reg.out;
	assign rd_data = st_reg.rdata;
	assign irq = |(st_reg.status & st_reg.mask);

	// =====================================================
	// checks
	chk_celsius_window: assert property (@(posedge clk_sys) disable iff (rst)
		(kind == KIND_TC && !st_reg.cfg[CFG_FAHR] && pv > hi + 20 * UNIT_PER_DEG && !adc_f && !mem_f
		&& disp_sel == SEL_PV) |=> out.disp1 == CODE_INPUT)
		else $error("thermal input beyond upper limit plus 20 not flagged");
	chk_fahr_window: assert property (@(posedge clk_sys) disable iff (rst)
		(kind == KIND_TC && st_reg.cfg[CFG_FAHR] && pv == hi + 40 * UNIT_PER_DEG && !adc_f && !mem_f)
		|=> out.disp1 != CODE_INPUT)
		else $error("fahrenheit margin of 40 not honoured");
	chk_analog_window: assert property (@(posedge clk_sys) disable iff (rst)
		(kind == KIND_ANA && dpv * 100 < span * (-5) && !adc_f && !mem_f && show_val)
		|=> out.disp1 == CODE_INPUT)
		else $error("analog input below -5 percent not flagged");
	chk_rtd_open: assert property (@(posedge clk_sys) disable iff (rst)
		(kind == KIND_RTD && (|pin_rtd_open) && !pin_adc_fault && !pin_mem_fault)
		[*3] ##1 (kind == KIND_RTD && !adc_f && !mem_f && disp_sel == SEL_PV) |=> out.disp1 == CODE_INPUT)
		else $error("open sensor line not reported as input fault");
	chk_fault_alarm: assert property (@(posedge clk_sys) disable iff (rst)
		(in_fault && !adc_f && !mem_f) |=> (out.alarm[ALM_N-1:1] == $past(alarm_hi_resp[ALM_N-1:1]))
		&& (out.alarm[0] == ($past(alarm_hi_resp[0]) || $past(st_reg.cfg[CFG_FTA]))))
		else $error("alarms not forced on input fault");
	chk_fault_ctrl_off: assert property (@(posedge clk_sys) disable iff (rst)
		(in_fault && !adc_f && !mem_f && st_reg.cfg[CFG_ERRMV + 2 -: 3] == 3'h0) |=> !out.ctrl_on)
		else $error("control output on during input fault");
	chk_err_display: assert property (@(posedge clk_sys) disable iff (rst)
		(in_fault && disp_sel == SEL_OTHER && !adc_f && !mem_f) |=> out.disp1 != CODE_INPUT)
		else $error("input fault shown outside value screens");
	chk_overrange: assert property (@(posedge clk_sys) disable iff (rst)
		(!in_fault && pv > 32400 && !adc_f && !mem_f && disp_sel == SEL_RSP)
		|=> out.disp1 == CODE_OVR_HI && out.ovr_rsp && out.ctrl_on == $past(ctrl_req_on))
		else $error("overrange not shown or control disturbed");
	chk_adc_off: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(adc_f) && !mem_f |=> !out.ctrl_on && out.alarm == '0 && out.disp1 == CODE_ADC)
		else $error("converter fault left outputs on");
	chk_mem_zero: assert property (@(posedge clk_sys) disable iff (rst)
		mem_f |=> out.cur_zero && !out.ctrl_on && out.ctrl_val == '0 && out.disp1 == CODE_MEM)
		else $error("memory fault left outputs on");
	chk_cur_limit: assert property (@(posedge clk_sys) disable iff (rst)
		(heater_cur == CUR_W'(CUR_LIMIT + 1) && st_reg.cfg[CFG_CUR2])
		|=> out.disp2 == CODE_CUR && st_reg.status[EV_CUR])
		else $error("heater current above 55.0 A not flagged");
endmodule // cfs_supervisor

// >>> hw/cfs_pkg.sv
package cfs_pkg;

	// =====================================================
	// widths
	localparam int PV_W = 20;
	localparam int MV_W = 16;
	localparam int ALM_N = 4;
	localparam int AW = 4;
	localparam int DW = 32;
	localparam int CUR_W = 12;
	localparam int EV_N = 5;

	// =====================================================
	// register offsets
	localparam logic [AW-1:0] ADDR_CFG = 4'h0;
	localparam logic [AW-1:0] ADDR_LO = 4'h1;
	localparam logic [AW-1:0] ADDR_HI = 4'h2;
	localparam logic [AW-1:0] ADDR_MV_ERR = 4'h3;
	localparam logic [AW-1:0] ADDR_MV_MAN = 4'h4;
	localparam logic [AW-1:0] ADDR_MV_RST = 4'h5;
	localparam logic [AW-1:0] ADDR_STATUS = 4'h6;
	localparam logic [AW-1:0] ADDR_MASK = 4'h7;
	localparam logic [AW-1:0] ADDR_LIVE = 4'h8;

	// =====================================================
	// field positions and reset values
	localparam int CFG_KIND = 0;
	localparam int CFG_FAHR = 2;
	localparam int CFG_FTA = 3;
	localparam int CFG_ERRMV = 4;
	localparam int CFG_MANMV = 5;
	localparam int CFG_RSTMV = 6;
	localparam int CFG_CUR2 = 7;
	localparam int EV_INPUT = 0;
	localparam int EV_OVR = 1;
	localparam int EV_ADC = 2;
	localparam int EV_MEM = 3;
	localparam int EV_CUR = 4;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [PV_W-1:0] LO_RST = 20'h00000;
	localparam logic [PV_W-1:0] HI_RST = 20'h003E8;
	localparam logic [MV_W-1:0] MV_RST = 16'h0000;
	localparam logic [EV_N-1:0] MASK_RST = 5'h00;

	// =====================================================
	// limits
	localparam int MARGIN_C = 20;
	localparam int MARGIN_F = 40;
	localparam int ANA_LO_PCT = -5;
	localparam int ANA_HI_PCT = 105;
	localparam int DISP_MIN = -19999;
	localparam int DISP_MAX = 32400;
	localparam int CUR_LIMIT_DA = 550;

	// =====================================================
	// types
	typedef enum logic [1:0] {KIND_TC = 2'h0, KIND_RTD = 2'h1, KIND_ANA = 2'h2} cfs_kind_t;
	typedef enum logic [2:0] {SEL_PV = 3'h0, SEL_PV_SP = 3'h1, SEL_PV_MV = 3'h2,
		SEL_RSP = 3'h3, SEL_OTHER = 3'h4} cfs_sel_t;
	typedef enum logic [2:0] {CODE_NONE = 3'h0, CODE_INPUT = 3'h1, CODE_OVR_LO = 3'h2,
		CODE_OVR_HI = 3'h3, CODE_ADC = 3'h4, CODE_MEM = 3'h5, CODE_CUR = 3'h6} cfs_code_t;
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} cfs_bus_t;
	typedef struct packed {
		logic ctrl_on;
		logic [MV_W-1:0] ctrl_val;
		logic [ALM_N-1:0] alarm;
		logic cur_zero;
		cfs_code_t disp1;
		cfs_code_t disp2;
		logic ovr_pv;
		logic ovr_rsp;
	} cfs_out_t;
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [7:0] cfg;
		logic [PV_W-1:0] lo;
		logic [PV_W-1:0] hi;
		logic [MV_W-1:0] mv_err;
		logic [MV_W-1:0] mv_man;
		logic [MV_W-1:0] mv_rst;
		logic [EV_N-1:0] status;
		logic [EV_N-1:0] mask;
		logic [DW-1:0] rdata;
		cfs_out_t out;
	} cfs_st_t;
endpackage

// >>> tb/cfs_plant.sv
`timescale 1ns/1ns
// =====================================================
// sensor and heater stage model
module cfs_plant
	import cfs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic signed [PV_W-1:0] pv_cmd,
	input wire logic [CUR_W-1:0] cur_cmd,
	input wire logic [2:0] open_cmd,
	input wire logic [1:0] int_cmd,
	output logic signed [PV_W-1:0] process_value,
	output logic [CUR_W-1:0] heater_cur,
	output logic [2:0] pin_rtd_open,
	output logic pin_adc_fault,
	output logic pin_mem_fault
);
	// front end converts once per clock, so every change lands one cycle late
	always_ff @(posedge clk_sys)
	begin
		process_value <= pv_cmd;
		heater_cur <= cur_cmd;
		pin_rtd_open <= open_cmd;
		pin_adc_fault <= int_cmd[0];
		pin_mem_fault <= int_cmd[1];
	end
endmodule // cfs_plant

// >>> tb/test_controller_fault_supervisor.sv
`timescale 1ns/1ns
module test_controller_fault_supervisor
	import cfs_pkg::*;
;
	logic clk_sys, rst, irq, ctrl_req_on, manual_act, reset_act, pin_adc_fault, pin_mem_fault;
	cfs_bus_t bus;
	logic [DW-1:0] rd_data;
	logic signed [PV_W-1:0] pv, process_value;
	logic [CUR_W-1:0] cur, heater_cur;
	logic [2:0] opn, pin_rtd_open;
	logic [1:0] intf;
	cfs_sel_t disp_sel;
	logic [MV_W-1:0] ctrl_req_val;
	logic [ALM_N-1:0] alarm_req, alarm_hi_resp;
	cfs_out_t out;
	int n_fail, checks;

	cfs_plant cfs_plant_i(.clk_sys(clk_sys), .pv_cmd(pv), .cur_cmd(cur), .open_cmd(opn), .int_cmd(intf),
		.process_value(process_value), .heater_cur(heater_cur), .pin_rtd_open(pin_rtd_open),
		.pin_adc_fault(pin_adc_fault), .pin_mem_fault(pin_mem_fault));
	cfs_supervisor cfs_supervisor_i(.clk_sys(clk_sys), .rst(rst), .bus(bus), .rd_data(rd_data),
		.process_value(process_value), .heater_cur(heater_cur), .disp_sel(disp_sel),
		.ctrl_req_on(ctrl_req_on), .ctrl_req_val(ctrl_req_val), .alarm_req(alarm_req),
		.alarm_hi_resp(alarm_hi_resp), .manual_act(manual_act), .reset_act(reset_act),
		.pin_rtd_open(pin_rtd_open), .pin_adc_fault(pin_adc_fault), .pin_mem_fault(pin_mem_fault),
		.out(out), .irq(irq));

	// =====================================================
	// tasks
	task report_and_stop;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task ck(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus <= {a, d, 2'b10};
		@(posedge clk_sys);
		bus <= '0;
	endtask

	task rd(input logic [AW-1:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		bus <= {a, 32'h0, 2'b01};
		@(posedge clk_sys);
		bus <= '0;
		#1;
		ck(rd_data, e);
	endtask

	// pin paths take three edges plus one in the plant
	task settle;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask

	task go(input int v);
		@(posedge clk_sys);
		pv <= PV_W'(v);
		settle;
	endtask

	task ck3(input cfs_code_t d, input logic on, input logic [3:0] a);
		ck(32'(out.disp1), 32'(d));
		ck(32'(out.ctrl_on), 32'(on));
		ck(32'(out.alarm), 32'(a));
	endtask

	task rng(input int v, input logic f);
		go(v);
		ck3(f ? CODE_INPUT : CODE_NONE, !f, f ? 4'hA : 4'h5);
	endtask

	task cv(input logic [15:0] v);
		ck(32'(out.ctrl_on), 32'h1);
		ck(32'(out.ctrl_val), 32'(v));
	endtask

	// =====================================================
	// stimulus
	initial
	begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end

	initial
	begin
		#(40 * 6000);
		n_fail++;
		report_and_stop;
	end

	initial
	begin
		rst = 1;
		bus = '0;
		pv = 0;
		cur = 0;
		opn = 0;
		intf = 0;
		disp_sel = SEL_PV;
		ctrl_req_on = 1;
		ctrl_req_val = 16'h1234;
		alarm_req = 4'h5;
		alarm_hi_resp = 4'hA;
		manual_act = 0;
		reset_act = 0;
		n_fail = 0;
		checks = 0;
		repeat (16) @(posedge clk_sys);
		ck(32'(out), 32'h0);
		ck(32'(irq), 32'h0);
		rst <= 0;
		rd(ADDR_CFG, 32'h0);
		rd(ADDR_LO, 32'h0);
		rd(ADDR_HI, 32'h3E8);
		for (int i = 3; i < 8; i++)
			rd(AW'(i), 32'h0);
		wr(4'hF, 32'hFF);
		rd(4'hF, 32'h0);
		wr(ADDR_LIVE, 32'h1F);
		rd(ADDR_LIVE, 32'h0);
		wr(ADDR_MASK, 32'h1F);
		rd(ADDR_MASK, 32'h1F);
		rng(2000, 1'b1);
		ck(32'(irq), 32'h1);
		rd(ADDR_STATUS, 32'h1);
		wr(ADDR_MASK, 32'h0);
		rng(500, 1'b0);
		ck(32'(irq), 32'h0);
		rd(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, 32'h0);
		rng(1020, 1'b0);
		rng(1021, 1'b1);
		rng(-20, 1'b0);
		rng(-21, 1'b1);
		wr(ADDR_CFG, 32'h4);
		rng(1040, 1'b0);
		rng(1041, 1'b1);
		rng(-41, 1'b1);
		wr(ADDR_CFG, 32'h2);
		rng(1050, 1'b0);
		rng(1051, 1'b1);
		rng(-50, 1'b0);
		rng(-51, 1'b1);
		wr(ADDR_CFG, 32'h1);
		rng(500, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			opn <= 3'(1 << i);
			settle;
			ck3(i < 3 ? CODE_INPUT : CODE_NONE, i > 2, i < 3 ? 4'hA : 4'h5);
		end
		rng(2000, 1'b1);
		for (int i = 1; i < 5; i++)
		begin
			@(posedge clk_sys);
			disp_sel <= cfs_sel_t'(i);
			settle;
			ck(32'(out.disp1), i < 3 ? 32'(CODE_INPUT) : 32'(CODE_NONE));
		end
		@(posedge clk_sys);
		disp_sel <= SEL_PV;
		alarm_hi_resp <= 4'h0;
		wr(ADDR_CFG, 32'h8);
		settle;
		ck(32'(out.alarm), 32'h1);
		wr(ADDR_MV_ERR, 32'h11);
		wr(ADDR_MV_MAN, 32'h22);
		wr(ADDR_MV_RST, 32'h33);
		wr(ADDR_CFG, 32'h70);
		manual_act <= 1;
		reset_act <= 1;
		settle;
		cv(16'h22);
		@(posedge clk_sys);
		manual_act <= 0;
		settle;
		cv(16'h33);
		@(posedge clk_sys);
		reset_act <= 0;
		settle;
		cv(16'h11);
		@(posedge clk_sys);
		intf <= 2'h1;
		settle;
		ck3(CODE_ADC, 1'b0, 4'h0);
		ck(32'(out.ctrl_val), 32'h0);
		ck(32'(out.cur_zero), 32'h0);
		@(posedge clk_sys);
		intf <= 2'h3;
		settle;
		ck3(CODE_MEM, 1'b0, 4'h0);
		ck(32'(out.cur_zero), 32'h1);
		@(posedge clk_sys);
		intf <= 2'h0;
		wr(ADDR_CFG, 32'h0);
		wr(ADDR_HI, 32'd40000);
		go(32401);
		ck3(CODE_OVR_HI, 1'b1, 4'h5);
		ck(32'(out.ovr_pv), 32'h1);
		@(posedge clk_sys);
		disp_sel <= SEL_RSP;
		settle;
		ck(32'(out.ovr_rsp), 32'h1);
		@(posedge clk_sys);
		disp_sel <= SEL_PV;
		rng(32400, 1'b0);
		wr(ADDR_LO, -32'd30000);
		go(-20000);
		ck3(CODE_OVR_LO, 1'b1, 4'h5);
		rng(-19999, 1'b0);
		rng(0, 1'b0);
		@(posedge clk_sys);
		cur <= 12'd550;
		settle;
		ck(32'(out.disp1), 32'(CODE_NONE));
		@(posedge clk_sys);
		cur <= 12'd551;
		settle;
		ck(32'(out.disp1), 32'(CODE_CUR));
		wr(ADDR_CFG, 32'h80);
		settle;
		ck(32'(out.disp2), 32'(CODE_CUR));
		report_and_stop;
	end
endmodule // test_controller_fault_supervisor
